// ---- verilog/ldw_write_path.sv ----
`timescale 1ns/100ps
`default_nettype none
module ldw_write_path
    import ldw_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire ldw_pkg::ldw_mode_t     drive_mode,
    input  wire logic                   bank_alt,
    input  wire logic                   ptr_load,
    input  wire logic [ldw_pkg::PTR_W-1:0] ptr_value,
    input  wire logic                   dev_select,
    input  wire logic [ldw_pkg::SUB_W-1:0] dev_select_value,
    input  wire logic                   hw_subaddr_pin_bit0,
    input  wire logic                   hw_subaddr_pin_bit1,
    input  wire logic                   hw_subaddr_pin_bit2,
    input  wire logic                   byte_start,
    input  wire logic                   bit_valid,
    input  wire logic                   bit_data,
    input  wire logic [ldw_pkg::PTR_W-1:0] rd_addr,
    output logic [ldw_pkg::RAM_ROWS-1:0] rd_data,
    output logic [ldw_pkg::PTR_W-1:0]   data_ptr,
    output logic [ldw_pkg::SUB_W-1:0]   subaddr_cnt,
    output logic                        store_enable
);
    import ldw_pkg::*;

    ldw_ram_if ram ();

    logic [2:0]       bit_idx;
    logic [2:0]       next_bit_idx;
    logic [PTR_W-1:0] next_data_ptr;
    logic [SUB_W-1:0] next_subaddr_cnt;
    logic [PTR_W-1:0] step;
    logic [2:0]       col_off;
    logic [1:0]       row;
    logic             bit_take;
    logic             addr_ok;
    logic [PTR_W:0]   waddr_wide;
    logic [PTR_W:0]   ptr_sum;
    logic [PTR_W-1:0] waddr;
    logic [SUB_W-1:0] hw_sub;

    assign hw_sub = {hw_subaddr_pin_bit2, hw_subaddr_pin_bit1,
                     hw_subaddr_pin_bit0};
    // hazard: pins are compared live, so they must stay still in an access
    assign store_enable = (subaddr_cnt == hw_sub);

    // map bit index (0 = MSB) to column offset and row per mode
    always_comb begin
        step     = STEP_STATIC;
        col_off  = bit_idx;
        row      = 2'(bank_alt ? 2 : 0);
        unique case (drive_mode)
            LDW_STATIC: begin
                step    = STEP_STATIC;
                col_off = bit_idx;
                row     = bank_alt ? 2'd2 : 2'd0;
            end
            LDW_MUX2: begin
                step    = STEP_MUX2;
                col_off = {1'b0, bit_idx[2:1]};
                row     = {bank_alt, bit_idx[0]};
            end
            LDW_MUX3: begin
                step     = STEP_MUX3;
                col_off  = 3'(bit_idx / 3);
                row      = 2'(bit_idx % 3); // nine slots, eight bits
            end
            LDW_MUX4: begin
                step    = STEP_MUX4;
                col_off = {2'b00, bit_idx[2]};
                row     = bit_idx[1:0];
            end
        endcase
    end

    // sums kept one bit wider so a write past the top cannot wrap to 0
    assign waddr_wide = {1'b0, data_ptr} + (PTR_W+1)'(col_off);
    assign waddr      = waddr_wide[PTR_W-1:0];
    assign addr_ok    = (waddr_wide <= {1'b0, LAST_ADR});
    assign ptr_sum    = {1'b0, data_ptr} + {1'b0, step};

    // a bit that meets a pointer load or byte start is not taken
    assign bit_take = bit_valid && !ptr_load && !byte_start;

    // write port: one RAM bit per incoming serial bit
    assign ram.we    = bit_take && store_enable && addr_ok;
    assign ram.waddr = waddr; // upper addresses gated in the RAM
    assign ram.wrow  = row;
    assign ram.wbit  = bit_data;
    assign ram.raddr = rd_addr;
    assign rd_data   = ram.rdata;

    // pointer, bit counter and subaddress next state
    always_comb begin
        next_bit_idx     = bit_idx;
        next_data_ptr    = data_ptr;
        next_subaddr_cnt = subaddr_cnt;
        if (dev_select) begin
            next_subaddr_cnt = dev_select_value;
        end
        if (ptr_load) begin
            next_data_ptr = ptr_value;
            next_bit_idx  = 3'd0;
        end else if (byte_start) begin
            next_bit_idx = 3'd0;
        end else if (bit_valid) begin
            next_bit_idx = bit_idx + 3'd1;
            if (bit_idx == 3'd7) begin
                // saturate so a runaway pointer cannot wrap into valid space
                if (data_ptr > LAST_ADR) begin
                    next_data_ptr = data_ptr;
                end else if (ptr_sum[PTR_W]) begin
                    next_data_ptr = '1; // clamp at the top
                end else begin
                    next_data_ptr = ptr_sum[PTR_W-1:0];
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bit_idx     <= 3'd0;
            data_ptr    <= PTR_RST;
            subaddr_cnt <= SUB_RST;
        end else begin
            bit_idx     <= next_bit_idx;
            data_ptr    <= next_data_ptr;
            subaddr_cnt <= next_subaddr_cnt;
        end
    end

    ldw_ram u_ram (
        .clk_sys (clk_sys),
        .port    (ram.mem)
    );

    // pointer stepping and loading
    a_ptr_step: assert property (
        @(posedge clk_sys) disable iff (rst)
        (bit_valid && bit_idx == 3'd7 && !ptr_load && !byte_start
         && drive_mode == LDW_MUX3 && data_ptr <= LAST_ADR)
        |=> data_ptr == $past(data_ptr) + STEP_MUX3)
        else $error("pointer did not advance by three");
    a_ptr_static: assert property (
        @(posedge clk_sys) disable iff (rst)
        (bit_take && bit_idx == 3'd7 && drive_mode == LDW_STATIC
         && data_ptr <= LAST_ADR - STEP_STATIC)
        |=> data_ptr == $past(data_ptr) + STEP_STATIC)
        else $error("pointer did not advance by eight");
    // a dropped byte still moves the pointer on
    a_drop_adv: assert property (
        @(posedge clk_sys) disable iff (rst)
        (bit_take && !store_enable && bit_idx == 3'd7
         && drive_mode == LDW_MUX4 && data_ptr <= LAST_ADR - STEP_MUX4)
        |=> data_ptr == $past(data_ptr) + STEP_MUX4)
        else $error("dropped byte did not advance pointer");
    // above the last word the pointer waits for a reload
    a_ptr_hold: assert property (
        @(posedge clk_sys) disable iff (rst)
        (!ptr_load && data_ptr > LAST_ADR) |=> data_ptr == $past(data_ptr))
        else $error("pointer moved above the last word");
    a_ptr_load: assert property (
        @(posedge clk_sys) disable iff (rst)
        ptr_load |=> data_ptr == $past(ptr_value) && bit_idx == 3'd0)
        else $error("pointer load missed");
    // bit counter: a byte start clears it, each taken bit moves it on
    a_byte_rst: assert property (
        @(posedge clk_sys) disable iff (rst)
        (byte_start && !ptr_load) |=> bit_idx == 3'd0)
        else $error("byte start did not clear bit counter");
    a_bit_count: assert property (
        @(posedge clk_sys) disable iff (rst)
        bit_take |=> bit_idx == $past(bit_idx) + 3'd1)
        else $error("bit counter did not advance");
    // storage gating and subaddress loading
    a_sub_gate: assert property (
        @(posedge clk_sys) disable iff (rst)
        ram.we |-> subaddr_cnt == hw_sub)
        else $error("write while subaddress mismatched");
    a_sel_load: assert property (
        @(posedge clk_sys) disable iff (rst)
        dev_select |=> subaddr_cnt == $past(dev_select_value))
        else $error("subaddress counter not loaded");
    // placement of each bit per mode
    a_static_row: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ram.we && drive_mode == LDW_STATIC)
        |-> ram.wrow == (bank_alt ? 2'd2 : 2'd0))
        else $error("static row wrong");
    a_mux2_row: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ram.we && drive_mode == LDW_MUX2)
        |-> ram.wrow[0] == bit_idx[0])
        else $error("1:2 row wrong");
    a_mux2_addr: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ram.we && drive_mode == LDW_MUX2)
        |-> (ram.waddr - data_ptr) == PTR_W'(bit_idx >> 1))
        else $error("1:2 address wrong");
    a_alt_mux2: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ram.we && drive_mode == LDW_MUX2) |-> ram.wrow[1] == bank_alt)
        else $error("1:2 bank row wrong");
    a_mux3_keep: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ram.we && drive_mode == LDW_MUX3)
        |-> ram.wrow != 2'd3
            && !(ram.wrow == 2'd2 && ram.waddr == data_ptr + PTR_W'(2)))
        else $error("1:3 write hit a kept row");
    a_mux4_addr: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ram.we && drive_mode == LDW_MUX4)
        |-> ram.waddr == data_ptr + PTR_W'(bit_idx[2]))
        else $error("1:4 address wrong");
endmodule : ldw_write_path
`default_nettype wire

// ---- verilog/ldw_pkg.sv ----
package ldw_pkg;
    localparam int RAM_WORDS = 60;
    localparam int RAM_ROWS  = 4;
    localparam int PTR_W     = 6;
    localparam int SUB_W     = 3;
    localparam logic [PTR_W-1:0] PTR_RST  = 6'h00;
    localparam logic [SUB_W-1:0] SUB_RST  = 3'h0;
    localparam logic [PTR_W-1:0] LAST_ADR = 6'h3b;
    localparam logic [PTR_W-1:0] STEP_STATIC = 6'h08;
    localparam logic [PTR_W-1:0] STEP_MUX2   = 6'h04;
    localparam logic [PTR_W-1:0] STEP_MUX3   = 6'h03;
    localparam logic [PTR_W-1:0] STEP_MUX4   = 6'h02;
    typedef enum logic [1:0] {
        LDW_STATIC,
        LDW_MUX2,
        LDW_MUX3,
        LDW_MUX4
    } ldw_mode_t;
endpackage : ldw_pkg

// ---- verilog/ldw_ram_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface ldw_ram_if;
    logic       we;
    logic [5:0] waddr;
    logic [1:0] wrow;
    logic       wbit;
    logic [5:0] raddr;
    logic [3:0] rdata;
    modport ctrl (output we, waddr, wrow, wbit, raddr, input rdata);
    modport mem  (input we, waddr, wrow, wbit, raddr, output rdata);
endinterface : ldw_ram_if
`default_nettype wire

// ---- verilog/ldw_ram.sv ----
`timescale 1ns/100ps
`default_nettype none
module ldw_ram
    import ldw_pkg::*;
(
    input  wire logic clk_sys,
    ldw_ram_if.mem    port
);
    logic [RAM_ROWS-1:0] mem [RAM_WORDS];
    logic [RAM_ROWS-1:0] rdata;

    // per-bit write keeps the other rows of the word untouched
    always_ff @(posedge clk_sys) begin
        if (port.we && port.waddr <= LAST_ADR) begin
            mem[port.waddr][port.wrow] <= port.wbit;
        end
        if (port.raddr <= LAST_ADR) begin
            rdata <= mem[port.raddr];
        end else begin
            rdata <= 4'h0;
        end
    end
    assign port.rdata = rdata;
endmodule : ldw_ram
`default_nettype wire

// ---- test/ldw_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// bus host stand-in: command pulses and msb-first bits off the falling edge
module ldw_host_model
    import ldw_pkg::*;
(
    input  wire logic clk_sys,
    output logic       ptr_load,
    output logic [5:0] ptr_value,
    output logic       dev_select,
    output logic [2:0] dev_select_value,
    output logic       byte_start,
    output logic       bit_valid,
    output logic       bit_data
);
    initial begin
        {ptr_load, ptr_value, dev_select, dev_select_value} = '0;
        {byte_start, bit_valid, bit_data} = '0;
    end
    // select is always followed by a pointer load from the bench
    task automatic cmd(input logic sel, input logic [5:0] v);
        @(negedge clk_sys);
        dev_select = sel;
        dev_select_value = v[2:0];
        ptr_load = !sel;
        ptr_value = v;
        @(negedge clk_sys);
        dev_select = 1'b0;
        ptr_load = 1'b0;
    endtask : cmd
    // bits back to back, no gap for an acknowledge
    task automatic send(input logic [7:0] b);
        @(negedge clk_sys);
        byte_start = 1'b1;
        for (int k = 0; k < 8; k++) begin
            @(negedge clk_sys);
            byte_start = 1'b0;
            bit_valid = 1'b1;
            bit_data = b[7-k];
        end
        @(negedge clk_sys);
        bit_valid = 1'b0;
    endtask : send
endmodule : ldw_host_model
`default_nettype wire

// ---- test/ldw_write_path_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module ldw_write_path_tb;
    import ldw_pkg::*;
    logic       clk_sys, rst, bank_alt, ptr_load, dev_select, store_enable;
    logic       byte_start, bit_valid, bit_data;
    logic [5:0] ptr_value, rd_addr, data_ptr, ptr;
    logic [2:0] dev_select_value, subaddr_cnt, pins, sub;
    logic [3:0] rd_data;
    logic [3:0] sh [0:63];
    ldw_mode_t  mode;
    int         fail_count = 0, comparisons = 0, cyc = 0;
    logic [5:0] steps [4] = '{STEP_STATIC, STEP_MUX2, STEP_MUX3, STEP_MUX4};
    ldw_host_model ldw_host_model_i(.clk_sys, .ptr_load, .ptr_value,
        .dev_select, .dev_select_value, .byte_start, .bit_valid, .bit_data);
    ldw_write_path ldw_write_path_i(.clk_sys, .rst, .drive_mode(mode),
        .bank_alt, .ptr_load, .ptr_value, .dev_select, .dev_select_value,
        .hw_subaddr_pin_bit0(pins[0]), .hw_subaddr_pin_bit1(pins[1]),
        .hw_subaddr_pin_bit2(pins[2]), .byte_start, .bit_valid, .bit_data,
        .rd_addr, .rd_data, .data_ptr, .subaddr_cnt, .store_enable);
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // hang guard, well above the few thousand cycles the run needs
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        if (fail_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic sel(input logic [2:0] v);
        sub = v;
        ldw_host_model_i.cmd(1'b1, {3'h0, v});
        `CHK(subaddr_cnt, v)
        `CHK(store_enable, v == pins)
    endtask : sel
    task automatic ld(input logic [5:0] v);
        ptr = v;
        ldw_host_model_i.cmd(1'b0, v);
    endtask : ld
    // shadow placement of one byte, then send it and check the pointer
    task automatic put(input logic [7:0] b);
        int n;
        int a;
        int r;
        n = int'(mode) + 1;
        for (int k = 0; k < 8; k++) begin
            a = ptr + k / n;
            r = k % n + ((bank_alt && n < 3) ? 2 : 0);
            if (sub == pins && a < 60) sh[a][r] = b[7-k];
        end
        if (ptr < 60) begin
            // the pointer clamps at the top rather than wrapping
            ptr = (ptr + steps[mode] > 63) ? 6'h3f : ptr + steps[mode];
        end
        ldw_host_model_i.send(b);
        `CHK(data_ptr, ptr)
    endtask : put
    // every word, including the four addresses past the end
    task automatic chk_ram;
        for (int a = 0; a < 64; a++) begin
            @(negedge clk_sys);
            rd_addr = a[5:0];
            @(negedge clk_sys);
            `CHK(rd_data, (a < 60) ? sh[a] : 4'h0)
        end
    endtask : chk_ram
    initial begin
        {rst, bank_alt, rd_addr, sub} = '0;
        rst = 1'b1;
        mode = LDW_MUX4;
        pins = 3'h5;
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        `CHK(data_ptr, PTR_RST)
        `CHK(subaddr_cnt, SUB_RST)
        sel(3'h5);
        ld(6'h00);
        repeat (30) put(8'hff);
        chk_ram();
        for (int m = 0; m < 8; m++) begin
            mode = ldw_mode_t'(m / 2);
            bank_alt = m[0];
            ld(6'h14);
            put(8'ha5 ^ m[7:0]);
            put(8'h3c);
            chk_ram();
        end
        sel(3'h3);
        ld(6'h28);
        put(8'h00);
        chk_ram();
        sel(3'h5);
        ld(6'h3a);
        put(8'h00);
        put(8'h00);
        chk_ram();
        // static byte running past the top must not wrap to address 0
        mode = LDW_STATIC;
        ld(6'h3a);
        put(8'h00);
        // reset in mid-run: pointer and counter clear, RAM is kept
        @(negedge clk_sys);
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        ptr = PTR_RST;
        sub = SUB_RST;
        `CHK(data_ptr, PTR_RST)
        `CHK(subaddr_cnt, SUB_RST)
        `CHK(store_enable, 1'b0)
        chk_ram();
        tally_and_finish();
    end
endmodule : ldw_write_path_tb
`default_nettype wire
